// *** core/bus_cycle_sequencer.sv ***
// What this block does
// - every instruction opens with an opcode fetch
// - index register step: two fetches, one idle
// - indexed memory step: eight cycles, read then write
// - direct port input: port low, accumulator high
// - page-zero input: upper address byte forced zero
// - jump skips high byte when condition fails
// - block input: io read, memory write, repeat idles
// - idle state: all strobes high, bus released
`timescale 1ns/1ps
`include "bus_cycle_defines.svh"
module bus_cycle_sequencer
  import bus_cycle_pkg::*;
(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_CLOCK_EN,
  // instruction request, held stable while busy
  input wire logic I_START,
  input wire cls_t I_CLASS,
  input wire logic I_CONDITION,
  input wire logic I_REPEAT,
  input wire logic [15:0] I_PC,
  input wire logic [15:0] I_INDEX,
  input wire logic [15:0] I_BC,
  input wire logic [15:0] I_HL,
  input wire logic [7:0] I_ACC,
  input wire logic [7:0] I_WRITE_DATA,
  // external bus
  input wire logic [7:0] I_DATA,
  output logic [7:0] O_DATA,
  output logic O_DATA_OE,
  output logic [15:0] O_ADDRESS,
  output logic O_READ_N,
  output logic O_WRITE_N,
  output logic O_MEMORY_REQUEST_N,
  output logic O_IO_REQUEST_N,
  output logic O_FETCH_CYCLE_MARKER_N,
  output logic O_HALT_N,
  output logic O_OPCODE_LEAD_MARKER,
  // status
  output logic O_BUSY,
  output logic O_DONE,
  output logic [7:0] O_OPERAND
);
  typedef struct packed {
    cyc_t cyc;
    logic [1:0] t;
    logic [2:0] step;
    cls_t cls;
    logic busy;
    logic done;
    logic pending;
    logic [15:0] pc;
    logic [7:0] opnd;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [15:0] addr;
    logic [7:0] dout;
    logic doe;
    logic rd_n;
    logic wr_n;
    logic memory_request_n;
    logic io_request_n;
    logic fetch_cycle_marker_n;
    logic halt_n;
    logic opcode_lead_marker;
  } state_t;

  state_t s;
  state_t next_s;
  logic rst_meta;
  logic rst_n;
  logic again;
  step_t cur;
  step_t nxt;

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic step_t pick(cls_t c, logic [2:0] st, logic cond, logic rep);
    step_t r;
    r = '{CYC_IDLE_STATE, 1'b1};
    if (st == `STEP_FIRST) begin
      r = '{CYC_FETCH1, 1'b0};
    end else begin
      unique case (c)
        CLS_INDEX_REG: begin
          if (st == 3'h1) r = '{CYC_FETCH2, 1'b0};
          else r = '{CYC_IDLE_STATE, 1'b1};
        end
        CLS_INDEX_MEM: begin
          unique case (st)
            3'h1: r = '{CYC_FETCH2, 1'b0};
            3'h2: r = '{CYC_OPERAND, 1'b0};
            3'h5: r = '{CYC_MEM_READ, 1'b0};
            3'h7: r = '{CYC_MEM_WRITE, 1'b1};
            default: r = '{CYC_IDLE_STATE, 1'b0};
          endcase
        end
        CLS_IN_DIRECT: begin
          if (st == 3'h1) r = '{CYC_OPERAND, 1'b0};
          else r = '{CYC_IO_READ, 1'b1};
        end
        CLS_IN_PAGE0: begin
          unique case (st)
            3'h1: r = '{CYC_FETCH2, 1'b0};
            3'h2: r = '{CYC_OPERAND, 1'b0};
            default: r = '{CYC_IO_READ, 1'b1};
          endcase
        end
        CLS_JUMP: begin
          r = '{CYC_OPERAND, (st == 3'h2) || !cond};
        end
        CLS_BLOCK_IN: begin
          unique case (st)
            3'h1: r = '{CYC_FETCH2, 1'b0};
            3'h2: r = '{CYC_IO_READ, 1'b0};
            3'h3: r = '{CYC_MEM_WRITE, !rep};
            3'h4: r = '{CYC_IDLE_STATE, 1'b0};
            default: r = '{CYC_IDLE_STATE, 1'b1};
          endcase
        end
        default: begin
          if (st == 3'h1) r = '{CYC_FETCH2, 1'b0};
          else r = '{CYC_IO_READ, 1'b1};
        end
      endcase
    end
    return r;
  endfunction

  assign again = I_REPEAT && (I_BC[15:8] != `COUNT_ONE);
  assign cur = pick(s.cls, s.step, I_CONDITION, again);
  assign nxt = pick(s.cls, 3'(s.step + 3'h1), I_CONDITION, again);

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sync1 = I_DATA;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.pending = 1'b0;
    if (s.pending && (s.sync2 == s.sync3)) begin
      next_s.opnd = s.sync3;
    end else if (s.pending) begin
      next_s.pending = 1'b1;
    end
    if (!s.busy) begin
      if (I_START) begin
        next_s.busy = 1'b1;
        next_s.cls = I_CLASS;
        next_s.step = `STEP_FIRST;
        next_s.t = `T_FIRST;
        next_s.pc = I_PC;
        next_s.cyc = CYC_FETCH1;
      end
    end else if ((s.cyc != CYC_IDLE_STATE) && (s.t != `T_LAST)) begin
      next_s.t = 2'(s.t + 2'h1);
    end else begin
      if (s.cyc == CYC_FETCH1 || s.cyc == CYC_FETCH2 || s.cyc == CYC_OPERAND) begin
        next_s.pc = 16'(s.pc + 16'h0001);
      end
      if (s.cyc == CYC_OPERAND) begin
        next_s.pending = 1'b1;
      end
      if (cur.last) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.step = 3'(s.step + 3'h1);
        next_s.cyc = nxt.kind;
        next_s.t = `T_FIRST;
      end
    end
    // bus outputs follow the next cycle kind
    next_s.addr = next_s.pc;
    next_s.dout = I_WRITE_DATA;
    next_s.doe = 1'b0;
    next_s.rd_n = `STROBE_OFF;
    next_s.wr_n = `STROBE_OFF;
    next_s.memory_request_n = `STROBE_OFF;
    next_s.io_request_n = `STROBE_OFF;
    next_s.fetch_cycle_marker_n = `STROBE_OFF;
    next_s.halt_n = `STROBE_OFF;
    next_s.opcode_lead_marker = 1'b1;
    if (next_s.busy) begin
      unique case (next_s.cyc)
        CYC_FETCH1, CYC_FETCH2: begin
          next_s.rd_n = `STROBE_ON;
          next_s.memory_request_n = `STROBE_ON;
          next_s.fetch_cycle_marker_n = `STROBE_ON;
          next_s.opcode_lead_marker = (next_s.cyc == CYC_FETCH2);
        end
        CYC_OPERAND: begin
          next_s.rd_n = `STROBE_ON;
          next_s.memory_request_n = `STROBE_ON;
        end
        CYC_MEM_READ: begin
          next_s.addr = 16'(I_INDEX + {{8{next_s.opnd[7]}}, next_s.opnd});
          next_s.rd_n = `STROBE_ON;
          next_s.memory_request_n = `STROBE_ON;
        end
        CYC_MEM_WRITE: begin
          if (next_s.cls == CLS_BLOCK_IN) next_s.addr = I_HL;
          else next_s.addr = 16'(I_INDEX + {{8{next_s.opnd[7]}}, next_s.opnd});
          next_s.wr_n = `STROBE_ON;
          next_s.memory_request_n = `STROBE_ON;
          next_s.doe = 1'b1;
        end
        CYC_IO_READ: begin
          if (next_s.cls == CLS_IN_DIRECT) next_s.addr = {I_ACC, next_s.opnd};
          else if (next_s.cls == CLS_IN_PAGE0) next_s.addr = {`PAGE_ZERO, next_s.opnd};
          else next_s.addr = I_BC;
          next_s.rd_n = `STROBE_ON;
          next_s.io_request_n = `STROBE_ON;
        end
        default: begin
          next_s.doe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{cyc: CYC_IDLE_STATE, cls: CLS_INDEX_REG, rd_n: 1'b1, wr_n: 1'b1, memory_request_n: 1'b1,
             io_request_n: 1'b1, fetch_cycle_marker_n: 1'b1, halt_n: 1'b1, opcode_lead_marker: 1'b1,
             default: '0};
    end else if (I_CLOCK_EN) begin
      s <= next_s;
    end
  end

  assign O_DATA = s.dout;
  assign O_DATA_OE = s.doe;
  assign O_ADDRESS = s.addr;
  assign O_READ_N = s.rd_n;
  assign O_WRITE_N = s.wr_n;
  assign O_MEMORY_REQUEST_N = s.memory_request_n;
  assign O_IO_REQUEST_N = s.io_request_n;
  assign O_FETCH_CYCLE_MARKER_N = s.fetch_cycle_marker_n;
  assign O_HALT_N = s.halt_n;
  assign O_OPCODE_LEAD_MARKER = s.opcode_lead_marker;
  assign O_BUSY = s.busy;
  assign O_DONE = s.done;
  assign O_OPERAND = s.opnd;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!rst_n);

  AST_FETCH_STROBES: assert property (!s.fetch_cycle_marker_n |->
    !s.rd_n && !s.memory_request_n && s.io_request_n && s.wr_n && s.halt_n && !s.doe)
    else $error("fetch strobes wrong");
  AST_FIRST_FETCH: assert property ($rose(s.busy) |->
    !s.fetch_cycle_marker_n && !s.opcode_lead_marker && s.addr == $past(I_PC))
    else $error("first cycle is not a plain fetch");
  AST_INDEX_REG_END: assert property (s.done && s.cls == CLS_INDEX_REG |-> s.step == 3'h2)
    else $error("index register step length wrong");
  AST_INDEX_MEM_WRITE: assert property (s.busy && s.cls == CLS_INDEX_MEM && s.cyc == CYC_MEM_WRITE |->
    s.step == 3'h7 && !s.wr_n && s.doe && s.addr == 16'(I_INDEX + {{8{s.opnd[7]}}, s.opnd}))
    else $error("indexed write wrong");
  AST_DIRECT_PORT: assert property (s.busy && s.cls == CLS_IN_DIRECT && s.cyc == CYC_IO_READ && s.t != `T_FIRST |->
    s.addr == {I_ACC, s.opnd} && s.memory_request_n && !s.io_request_n && !s.rd_n)
    else $error("direct port read wrong");
  AST_PAGE_ZERO: assert property (s.busy && s.cls == CLS_IN_PAGE0 && s.cyc == CYC_IO_READ |->
    s.addr[15:8] == `PAGE_ZERO && s.step == 3'h3)
    else $error("page-zero upper byte not zero");
  AST_JUMP_END: assert property (s.done && s.cls == CLS_JUMP |-> s.step == (I_CONDITION ? 3'h2 : 3'h1))
    else $error("jump length wrong");
  AST_BLOCK_END: assert property (s.done && s.cls == CLS_BLOCK_IN |-> s.step == (again ? 3'h5 : 3'h3))
    else $error("block input length wrong");
  AST_IDLE_QUIET: assert property (!s.busy || s.cyc == CYC_IDLE_STATE |->
    s.rd_n && s.wr_n && s.memory_request_n && s.io_request_n && s.fetch_cycle_marker_n
    && s.halt_n && s.opcode_lead_marker && !s.doe)
    else $error("idle state drives the bus");

  COV_INDEX_MEM: cover property (s.done && s.cls == CLS_INDEX_MEM);
  COV_BLOCK_REPEAT: cover property (s.done && s.cls == CLS_BLOCK_IN && s.step == 3'h5);
  COV_JUMP_SKIP: cover property (s.done && s.cls == CLS_JUMP && s.step == 3'h1);
  COV_PAGE_ZERO: cover property (s.done && s.cls == CLS_IN_PAGE0);
endmodule

// *** core/bus_cycle_defines.svh ***
`ifndef BUS_CYCLE_DEFINES_SVH
`define BUS_CYCLE_DEFINES_SVH
// bus cycle state counts
`define T_FIRST 2'h0
`define T_LAST 2'h2
`define STEP_FIRST 3'h0
// page-zero upper address byte
`define PAGE_ZERO 8'h00
// counter value that reaches zero after one more transfer
`define COUNT_ONE 8'h01
// level of an idle strobe
`define STROBE_OFF 1'b1
`define STROBE_ON 1'b0
`endif

// *** core/bus_cycle_pkg.sv ***
package bus_cycle_pkg;
  typedef enum logic [2:0] {
    CLS_INDEX_REG = 3'h0,
    CLS_INDEX_MEM = 3'h1,
    CLS_IN_DIRECT = 3'h2,
    CLS_IN_PAGE0 = 3'h3,
    CLS_JUMP = 3'h4,
    CLS_BLOCK_IN = 3'h5,
    CLS_IN_REG = 3'h6
  } cls_t;
  typedef enum logic [2:0] {
    CYC_FETCH1 = 3'h0,
    CYC_FETCH2 = 3'h1,
    CYC_OPERAND = 3'h2,
    CYC_MEM_READ = 3'h3,
    CYC_MEM_WRITE = 3'h4,
    CYC_IO_READ = 3'h5,
    CYC_IDLE_STATE = 3'h6
  } cyc_t;
  typedef struct packed {
    cyc_t kind;
    logic last;
  } step_t;
endpackage

// *** tb/bus_partner.sv ***
`timescale 1ns/1ps
module bus_partner (
  // bus side
  input wire logic clk,
  input wire logic [15:0] address,
  input wire logic read_n,
  input wire logic io_request_n,
  output logic [7:0] data
);
  logic [7:0] value;
  logic [7:0] last = 8'h00;
  logic held = 1'b0;
  // memory and port contents follow the address
  assign value = io_request_n ? address[7:0] + 8'h80 : address[7:0] ^ 8'h0F;
  // byte held two clocks past the read, then a changing pattern
  always @(posedge clk) begin
    if (!read_n) begin
      last <= value;
      held <= 1'b1;
    end else if (held) begin
      held <= 1'b0;
    end else begin
      last <= ~last;
    end
  end
  assign data = !read_n ? value : last;
endmodule

// *** tb/bus_cycle_sequencer_inc_in_jp_tb_top.sv ***
`timescale 1ns/1ps
module bus_cycle_sequencer_inc_in_jp_tb_top;
  import bus_cycle_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  cls_t cls = CLS_INDEX_REG;
  logic cond = 1'b0;
  logic rep = 1'b0;
  logic en = 1'b1;
  logic [15:0] pc = 16'h1234;
  logic [15:0] ix = 16'h4000;
  logic [15:0] bc = 16'h0105;
  logic [15:0] hl = 16'h8001;
  logic [7:0] acc = 8'hA5;
  logic [7:0] wdata = 8'h3C;
  logic [7:0] din, dout, opnd, pins;
  logic oe, read_n, write_n, memory_request_n, io_request_n, fetch_cycle_marker_n;
  logic halt_n, opcode_lead_marker, busy, done;
  logic [15:0] addr;
  int errors = 0;
  int samples_checked = 0;
  cyc_t kinds[$];
  logic [15:0] addrs[$];

  initial begin
    forever #20 clk = ~clk;
  end

  bus_cycle_sequencer dut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_CLOCK_EN(en), .I_START(start), .I_CLASS(cls),
    .I_CONDITION(cond), .I_REPEAT(rep), .I_PC(pc), .I_INDEX(ix), .I_BC(bc), .I_HL(hl),
    .I_ACC(acc), .I_WRITE_DATA(wdata), .I_DATA(din), .O_DATA(dout), .O_DATA_OE(oe),
    .O_ADDRESS(addr), .O_READ_N(read_n), .O_WRITE_N(write_n),
    .O_MEMORY_REQUEST_N(memory_request_n), .O_IO_REQUEST_N(io_request_n),
    .O_FETCH_CYCLE_MARKER_N(fetch_cycle_marker_n), .O_HALT_N(halt_n),
    .O_OPCODE_LEAD_MARKER(opcode_lead_marker), .O_BUSY(busy), .O_DONE(done), .O_OPERAND(opnd)
  );
  bus_partner partner (.clk(clk), .address(addr), .read_n(read_n), .io_request_n(io_request_n), .data(din));

  assign pins = {read_n, write_n, memory_request_n, io_request_n, fetch_cycle_marker_n, halt_n,
                 opcode_lead_marker, oe};

  task automatic close_out;
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read strobe, write, memory, io, fetch marker, halt, lead marker, output enable
  function automatic logic [7:0] strobes(input cyc_t k);
    case (k)
      CYC_FETCH1: strobes = 8'h54;
      CYC_FETCH2: strobes = 8'h56;
      CYC_OPERAND, CYC_MEM_READ: strobes = 8'h5E;
      CYC_MEM_WRITE: strobes = 8'h9F;
      CYC_IO_READ: strobes = 8'h6E;
      default: strobes = 8'hFE;
    endcase
  endfunction

  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] + 8'h80;
  endfunction

  task automatic add(input cyc_t k, input logic [15:0] a);
    kinds.push_back(k);
    addrs.push_back(a);
  endtask

  task automatic go(input cls_t c, input logic cd, input logic rp, input logic [15:0] b);
    @(posedge clk);
    cls <= c;
    cond <= cd;
    rep <= rp;
    bc <= b;
    start <= 1'b1;
    kinds.delete();
    addrs.delete();
    add(CYC_FETCH1, pc);
  endtask

  // walks the queued cycles state by state, then expects the done pulse
  task automatic run(input logic again);
    @(posedge clk);
    start <= 1'b0;
    foreach (kinds[i]) begin
      for (int t = 0; t < (kinds[i] == CYC_IDLE_STATE ? 1 : 3); t++) begin
        #1;
        chk("strobes", {8'h00, strobes(kinds[i])}, {8'h00, pins});
        chk("busy", 16'h0001, {15'h0000, busy});
        if (t > 0) chk("address", addrs[i], addr);
        if (kinds[i] == CYC_MEM_WRITE) chk("data", {8'h00, wdata}, {8'h00, dout});
        @(posedge clk);
      end
    end
    start <= again;
    #1;
    chk("done", 16'h0002, {14'h0000, done, busy});
    chk("end strobes", 16'h00FE, {8'h00, pins});
  endtask

  task automatic s_index_reg;
    go(CLS_INDEX_REG, 1'b0, 1'b0, bc);
    add(CYC_FETCH2, pc + 16'h0001);
    add(CYC_IDLE_STATE, 16'h0000);
    run(1'b0);
  endtask

  task automatic s_index_mem;
    logic [7:0] d;
    logic [15:0] ea;
    d = mem(pc + 16'h0002);
    ea = ix + {{8{d[7]}}, d};
    go(CLS_INDEX_MEM, 1'b0, 1'b0, bc);
    add(CYC_FETCH2, pc + 16'h0001);
    add(CYC_OPERAND, pc + 16'h0002);
    add(CYC_IDLE_STATE, 16'h0000);
    add(CYC_IDLE_STATE, 16'h0000);
    add(CYC_MEM_READ, ea);
    add(CYC_IDLE_STATE, 16'h0000);
    add(CYC_MEM_WRITE, ea);
    run(1'b0);
  endtask

  task automatic s_port_in(input logic page);
    go(page ? CLS_IN_PAGE0 : CLS_IN_DIRECT, 1'b0, 1'b0, bc);
    if (page) add(CYC_FETCH2, pc + 16'h0001);
    add(CYC_OPERAND, pc + {15'h0000, page} + 16'h0001);
    add(CYC_IO_READ, {page ? 8'h00 : acc, mem(pc + {15'h0000, page} + 16'h0001)});
    run(1'b0);
  endtask

  task automatic s_jump(input logic c);
    go(CLS_JUMP, c, 1'b0, bc);
    add(CYC_OPERAND, pc + 16'h0001);
    if (c) add(CYC_OPERAND, pc + 16'h0002);
    run(1'b0);
    @(posedge clk);
    #1;
    chk("operand", {8'h00, mem(pc + {15'h0000, c} + 16'h0001)}, {8'h00, opnd});
  endtask

  task automatic s_block(input logic rp, input logic [15:0] b, input logic again);
    go(CLS_BLOCK_IN, 1'b0, rp, b);
    add(CYC_FETCH2, pc + 16'h0001);
    add(CYC_IO_READ, b);
    add(CYC_MEM_WRITE, hl);
    if (rp && b[15:8] != 8'h01) add(CYC_IDLE_STATE, 16'h0000);
    if (rp && b[15:8] != 8'h01) add(CYC_IDLE_STATE, 16'h0000);
    run(again);
    if (again) run(1'b0);
  endtask

  task automatic s_in_reg;
    go(CLS_IN_REG, 1'b0, 1'b0, 16'h2233);
    add(CYC_FETCH2, pc + 16'h0001);
    add(CYC_IO_READ, 16'h2233);
    run(1'b0);
  endtask

  // clock enable low freezes the first fetch, the instruction then ends late
  task automatic s_hold;
    go(CLS_INDEX_REG, 1'b0, 1'b0, bc);
    @(posedge clk);
    start <= 1'b0;
    en <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("frozen strobes", {8'h00, strobes(CYC_FETCH1)}, {8'h00, pins});
    chk("frozen address", pc, addr);
    @(posedge clk);
    en <= 1'b1;
    repeat (7) @(posedge clk);
    #1;
    chk("late done", 16'h0002, {14'h0000, done, busy});
  endtask

  // reset in the middle of an instruction releases the bus at once
  task automatic s_reset;
    go(CLS_INDEX_MEM, 1'b0, 1'b0, bc);
    @(posedge clk);
    start <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset strobes", 16'h00FE, {8'h00, pins});
    chk("reset state", 16'h0000, {14'h0000, done, busy});
    chk("reset address", 16'h0000, addr);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("release strobes", 16'h00FE, {8'h00, pins});
    chk("release state", 16'h0000, {14'h0000, done, busy});
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    s_index_reg();
    s_index_mem();
    s_port_in(1'b0);
    s_port_in(1'b1);
    s_jump(1'b1);
    s_jump(1'b0);
    s_block(1'b0, 16'h0105, 1'b0);
    s_block(1'b1, 16'h0105, 1'b1);
    s_block(1'b1, 16'h4201, 1'b0);
    s_hold();
    s_reset();
    s_in_reg();
    close_out();
  end

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
